// file: src/sbsc_regs.svh
// Constants for the synchronous burst SRAM control decode.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SBSC_REGS_SVH
`define SBSC_REGS_SVH
`define SBSC_ADDR_W 16
`define SBSC_DATA_W 18
`define SBSC_LANES 2
`define SBSC_LANE_W 9
`define SBSC_DEPTH 65536
`define SBSC_BURST_W 2
`define SBSC_ADDR_RST 16'h0000
`define SBSC_CNT_RST 2'h0
`define SBSC_DATA_RST 18'h00000
`endif

// file: src/sbsc_pkg.sv
// Types for the synchronous burst SRAM control decode.
// Assumes sbsc_regs.svh is on the include path.
`include "sbsc_regs.svh"
package sbsc_pkg;
  typedef struct packed {
    logic global_write_strobe_n;
    logic byte_write_qualifier_n;
    logic [`SBSC_LANES-1:0] byte_lane_write_select_n;
  } sbsc_wr_t;
  typedef struct packed {
    logic chip_select_first_n;
    logic chip_select_second;
    logic chip_select_third_n;
  } sbsc_cs_t;
  typedef struct packed {
    logic processor_address_strobe_n;
    logic controller_address_strobe_n;
    logic burst_advance_n;
  } sbsc_strb_t;
  typedef enum logic [1:0] {
    SBSC_IDLE,
    SBSC_READ,
    SBSC_WRITE
  } sbsc_state_t;
endpackage : sbsc_pkg

// file: src/sbsc_core.sv
// Control decode and storage of a 64K x 18 flow-through burst SRAM.
// Assumes all inputs are synchronous to core_clk; data lane is split into in, out, enable.
`include "sbsc_regs.svh"
module sbsc_core (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [`SBSC_ADDR_W-1:0] addr,
  input wire sbsc_pkg::sbsc_wr_t wr,
  input wire sbsc_pkg::sbsc_cs_t cs,
  input wire sbsc_pkg::sbsc_strb_t strb,
  input wire logic burst_order_select,
  input wire logic output_enable_n,
  input wire logic [`SBSC_DATA_W-1:0] data_lane_in,
  output logic [`SBSC_DATA_W-1:0] data_lane_out,
  output logic data_lane_oe,
  output logic [`SBSC_ADDR_W-1:0] cur_addr,
  output logic selected
);
  // The array is far too large to clear, so it is written but never reset.
  logic [`SBSC_DATA_W-1:0] mem [0:`SBSC_DEPTH-1];

  // Burst address group.
  logic [`SBSC_ADDR_W-1:0] base_ff;
  logic [`SBSC_ADDR_W-1:0] nxt_base;
  logic [`SBSC_BURST_W-1:0] cnt_ff;
  logic [`SBSC_BURST_W-1:0] nxt_cnt;

  // Select group.
  logic sel_ff;
  logic nxt_sel;

  // Cycle kind group.
  sbsc_pkg::sbsc_state_t state_ff;
  sbsc_pkg::sbsc_state_t nxt_state;

  // Read data group.
  logic [`SBSC_DATA_W-1:0] rd_ff;
  logic [`SBSC_DATA_W-1:0] nxt_rd;

  // Controls decoded for the current edge.
  logic any_strobe;
  logic step_burst;
  logic is_write;
  logic do_write;
  logic do_read;
  logic [`SBSC_LANES-1:0] lane_we;
  logic [`SBSC_ADDR_W-1:0] acc_addr;

  // Burst word offset from the start offset and the step count.
  function automatic logic [`SBSC_BURST_W-1:0] burst_ofs(
    input logic [`SBSC_BURST_W-1:0] start,
    input logic [`SBSC_BURST_W-1:0] step,
    input logic interleave
  );
    if (interleave) begin
      burst_ofs = start ^ step;
    end else begin
      burst_ofs = start + step;
    end
  endfunction : burst_ofs

  // Full word address: the upper bits stay, the low bits follow the burst order.
  function automatic logic [`SBSC_ADDR_W-1:0] burst_addr(
    input logic [`SBSC_ADDR_W-1:0] base,
    input logic [`SBSC_BURST_W-1:0] step,
    input logic interleave
  );
    burst_addr = base;
    burst_addr[`SBSC_BURST_W-1:0] = burst_ofs(base[`SBSC_BURST_W-1:0], step, interleave);
  endfunction : burst_addr

  // All three enables must agree; any one of them alone deselects the part.
  function automatic logic chip_enable(
    input sbsc_pkg::sbsc_cs_t c
  );
    chip_enable = !c.chip_select_first_n && c.chip_select_second &&
      !c.chip_select_third_n;
  endfunction : chip_enable

  // The global strobe writes both lanes; otherwise the qualifier gates each lane.
  function automatic logic [`SBSC_LANES-1:0] lane_writes(
    input sbsc_pkg::sbsc_wr_t w
  );
    for (int i = 0; i < `SBSC_LANES; i++) begin
      lane_writes[i] = !w.global_write_strobe_n ||
        (!w.byte_write_qualifier_n && !w.byte_lane_write_select_n[i]);
    end
  endfunction : lane_writes

  always_comb begin
    any_strobe = !strb.processor_address_strobe_n || !strb.controller_address_strobe_n;
    // A strobe outranks advance, so a tied strobe never lets the counter run.
    step_burst = !any_strobe && !strb.burst_advance_n;
    lane_we = lane_writes(wr);
    is_write = |lane_we;
  end

  always_comb begin
    nxt_base = base_ff;
    nxt_cnt = cnt_ff;
    if (any_strobe) begin
      // Tied strobes make this branch taken every clock, so each cycle loads fresh.
      nxt_base = addr;
      nxt_cnt = `SBSC_CNT_RST;
    end else if (step_burst) begin
      nxt_cnt = cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      base_ff <= `SBSC_ADDR_RST;
      cnt_ff <= `SBSC_CNT_RST;
    end else begin
      base_ff <= nxt_base;
      cnt_ff <= nxt_cnt;
    end
  end

  // The select decision is only taken at a strobe and then rides through the burst.
  always_comb begin
    nxt_sel = sel_ff;
    if (any_strobe) begin
      nxt_sel = chip_enable(cs);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sel_ff <= 1'b0;
    end else begin
      sel_ff <= nxt_sel;
    end
  end

  // The access address is that of this edge, so a write lands where it is sampled.
  always_comb begin
    acc_addr = burst_addr(nxt_base, nxt_cnt, burst_order_select);
    do_write = nxt_sel && is_write;
    do_read = nxt_sel && !is_write;
  end

  always_comb begin
    nxt_state = sbsc_pkg::SBSC_IDLE;
    case ({do_write, do_read})
      2'b10: nxt_state = sbsc_pkg::SBSC_WRITE;
      2'b01: nxt_state = sbsc_pkg::SBSC_READ;
      default: nxt_state = sbsc_pkg::SBSC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= sbsc_pkg::SBSC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Read data holds until the next selected read, and a selected bus idle counts as one, re-reading the held address.
  always_comb begin
    nxt_rd = rd_ff;
    if (do_read) begin
      nxt_rd = mem[acc_addr];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_ff <= `SBSC_DATA_RST;
    end else begin
      rd_ff <= nxt_rd;
    end
  end

  // Storage has no reset, so it sits in its own clocked process.
  always_ff @(posedge core_clk) begin
    if (do_write) begin
      for (int i = 0; i < `SBSC_LANES; i++) begin
        if (lane_we[i]) begin
          mem[acc_addr][i*`SBSC_LANE_W +: `SBSC_LANE_W] <=
            data_lane_in[i*`SBSC_LANE_W +: `SBSC_LANE_W];
        end
      end
    end
  end

  // Output enable only drives during reads; in a write its level is not looked at.
  // A master that leaves it low into a write still sees it driven in that cycle, as state_ff holds the previous READ until the edge.
  always_comb begin
    case (state_ff)
      sbsc_pkg::SBSC_READ: data_lane_oe = !output_enable_n;
      sbsc_pkg::SBSC_WRITE: data_lane_oe = 1'b0;
      default: data_lane_oe = 1'b0;
    endcase
  end

  // The order select is read live; changing it inside a burst reorders the rest of it.
  assign data_lane_out = rd_ff;
  assign cur_addr = burst_addr(base_ff, cnt_ff, burst_order_select);
  assign selected = sel_ff;
endmodule : sbsc_core

// file: tb/sbsc_props.sv
// Checker for the burst SRAM control decode.
// Assumes a bind to sbsc_core and a single clock.
module sbsc_props (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [15:0] addr,
  input wire sbsc_pkg::sbsc_wr_t wr,
  input wire sbsc_pkg::sbsc_cs_t cs,
  input wire sbsc_pkg::sbsc_strb_t strb,
  input wire logic data_lane_oe,
  input wire logic [15:0] cur_addr,
  input wire logic selected
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire ld = !(strb.processor_address_strobe_n && strb.controller_address_strobe_n);
  wire w = !wr.global_write_strobe_n ||
    !(wr.byte_write_qualifier_n || &wr.byte_lane_write_select_n);
  sequence s_hit;
    ld && cs == 3'h2;
  endsequence
  sel_on_a: assert property (s_hit |=> selected)
    else $error("select lost");
  sel_off_a: assert property (ld && cs != 3'h2 |=> !selected)
    else $error("select wrong");
  oe_write_a: assert property (s_hit ##0 w |=> !data_lane_oe)
    else $error("output on in write");
  addr_load_a: assert property (ld |=> cur_addr == $past(addr))
    else $error("address not loaded");
  burst_step_a: assert property (!ld && !strb.burst_advance_n |=> !$stable(cur_addr[1:0]))
    else $error("no burst step");
endmodule : sbsc_props
bind sbsc_core sbsc_props u_props (.*);

// file: tb/sbsc_master.sv
// Bus master model: controls output enable around writes.
// Assumes wr changes just after a clock edge.
module sbsc_master (
  input wire sbsc_pkg::sbsc_wr_t wr,
  output logic output_enable_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released on any write intent so read data never fights write data.
  assign output_enable_n = !wr.global_write_strobe_n || !wr.byte_write_qualifier_n;
endmodule : sbsc_master

// file: tb/sync_burst_sram_control_test.sv
// Bench for the burst SRAM control decode.
// Assumes the core, master model and checker are compiled first.
module sync_burst_sram_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, nrst = 0, burst_order_select = 0, output_enable_n, data_lane_oe, selected;
  logic [15:0] addr = 0, cur_addr;
  logic [17:0] data_lane_in = 0, data_lane_out;
  sbsc_pkg::sbsc_wr_t wr = 4'hf;
  sbsc_pkg::sbsc_cs_t cs = 3'h2;
  sbsc_pkg::sbsc_strb_t strb = 3'h7;
  int miscompares = 0, num_checks = 0;
  sbsc_core u_dut (.*);
  sbsc_master u_master (.*);
  initial forever #5 core_clk = ~core_clk;
  task automatic cyc(logic [15:0] a, logic [3:0] w, logic [2:0] s, c = 3'h2, logic [17:0] d = 0);
    @(posedge core_clk);
    {addr, wr, strb, cs, data_lane_in} <= {a, w, s, c, d};
  endtask : cyc
  task automatic chk(string n, logic [17:0] e, g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // A fresh address every clock; the last write is a single lane.
  task automatic t_stream;
    for (int i = 0; i < 4; i++) cyc(16'h20 + i, 4'h7, 3'h5, 3'h2, 18'h2a550 + i);
    cyc(16'h22, 4'hc, 3'h5);
    cyc(16'h21, 4'ha, 3'h5, 3'h2, 18'h3ffff);
    for (int i = 0; i < 5; i++) begin
      cyc(16'h20 + i, 4'hf, 3'h5);
      @(negedge core_clk);
      chk("oe", i > 0, data_lane_oe);
      if (i > 0) chk("data", i == 2 ? 18'h2a5ff : 18'h2a54f + i, data_lane_out);
    end
  endtask : t_stream
  task automatic t_desel;
    for (int i = 0; i < 3; i++) begin
      cyc(16'h20, 4'h7, 3'h3, 3'h2 ^ (3'h4 >> i));
      cyc(16'h20, 4'hf, 3'h7);
      @(negedge core_clk);
      chk("sel", 0, selected);
    end
  endtask : t_desel
  // Strobe with advance low must load, not step; then one linear step wraps the low bits, and two steps give the same word in either order.
  task automatic t_burst(logic o, logic [15:0] a1);
    cyc(16'h13, 4'hf, 3'h4);
    burst_order_select <= o;
    cyc(16'h0, 4'hf, 3'h6);
    cyc(16'h0, 4'hf, 3'h6);
    @(negedge core_clk);
    chk("addr", a1, cur_addr);
    cyc(16'h0, 4'hf, 3'h7);
    @(negedge core_clk);
    chk("addr", 18'h11, cur_addr);
  endtask : t_burst
  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    t_stream();
    t_desel();
    t_burst(1'b0, 16'h10);
    t_burst(1'b1, 16'h12);
    tally_and_finish();
  end
  initial begin
    #5000;
    miscompares++;
    tally_and_finish();
  end
endmodule : sync_burst_sram_control_test
